/* File: src/scpc_pkg.sv */
// Package with register map, reset values and timing for the clock prescaler control
package scpc_pkg;
  localparam logic [15:0] SCPC_SLOW_OSC_MODE_ADDR = 16'hff58;
  localparam logic [15:0] SCPC_PERIPH_DIV_ADDR    = 16'hfff3;
  localparam logic [15:0] SCPC_CPU_DIV_ADDR       = 16'hfffb;
  localparam logic [7:0]  SCPC_SLOW_OSC_MODE_RST  = 8'h00;
  localparam logic [7:0]  SCPC_PERIPH_DIV_RST     = 8'h02;
  localparam logic [7:0]  SCPC_CPU_DIV_RST        = 8'h02;
  localparam int          SCPC_HALT_BIT           = 0;
  localparam int          SCPC_CPU_SEL_BIT        = 1;
  localparam int          SCPC_PDIV_LO_BIT        = 0;
  localparam int          SCPC_PDIV_HI_BIT        = 1;
  localparam int          SCPC_CLK_PERIOD_PS      = 10000;
  localparam int          SCPC_STOP_MIN_NS        = 277000;
  localparam int          SCPC_STOP_MIN_CYC       = (SCPC_STOP_MIN_NS * 1000 + SCPC_CLK_PERIOD_PS - 1)
                                                    / SCPC_CLK_PERIOD_PS;

  typedef struct packed {
    logic       wr;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } scpc_wr_t;

  typedef struct packed {
    logic cpu_en;
    logic periph_en;
  } scpc_en_t;
endpackage

/* File: src/scpc_div.sv */
// Power-of-two clock enable divider, switching ratio only at period boundaries
`timescale 1ns/10ps
module scpc_div
  import scpc_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_en,
  input  wire logic [1:0]       log2_ratio,
  output logic                  out_en
);
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic [1:0]       ratio_q, ratio_d;
  logic [WIDTH-1:0] top;

  always_comb
  begin
    top     = WIDTH'((1 << ratio_q) - 1);
    cnt_d   = cnt_q;
    ratio_d = ratio_q;
    out_en  = 1'b0;
    if (in_en)
    begin
      if (cnt_q >= top)
      begin
        out_en  = 1'b1;
        cnt_d   = '0;
        ratio_d = log2_ratio; // Ratio changes only at period end
      end
      else
      begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_q   <= '0;
      ratio_q <= 2'd0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      ratio_q <= ratio_d;
    end
  end
endmodule

/* File: src/scpc_top.sv */
// System clock prescaler control: registers, source select, power-on stop, dividers
// Functional notes
// - Reset loads both divider registers with 02h.
// - CPU clock divides system clock by 1,2,4,4,8,16 per codes; others prohibited.
// - Peripheral clock is divide-by-2 at 01h, divide-by-4 at 02h.
// - Peripheral field 00 gives undivided clock; 11 prohibited.
// - Peripheral clock derives from system clock; CPU clock from peripheral clock.
// - Non-stoppable option ignores mode writes, keeps oscillator, forces watchdog source.
// - Mode bit 0: 0 oscillates, 1 stops, when software stop permitted.
// - Reset clears slow oscillator mode register to 00h.
// - Slow oscillator always starts after reset release.
// - Registers accept single-bit and whole-byte writes.
// - System clock source chosen only by boot option.
// - Fast oscillator selected releases external clock pin as port.
// - Fast oscillator source starts CPU without stabilization wait.
// - After power-on, operation stopped 277 us to 1.075 ms, option read first.
`timescale 1ns/10ps
module scpc_top
  import scpc_pkg::*;
#(
  parameter int STOP_CYCLES = SCPC_STOP_MIN_CYC
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        opt_use_ext_clock,
  input  wire logic        opt_slow_osc_fixed,
  input  wire logic        fast_osc_tick,
  input  wire logic        ext_clock_pin,
  input  wire logic        wr,
  input  wire logic        bit_op,
  input  wire logic [2:0]  bit_sel,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic [7:0]       rdata,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             slow_osc_run,
  output logic             watchdog_src_forced,
  output logic             ext_pin_is_port,
  output logic             clock_ready
);
  typedef enum logic [1:0] {SCPC_STOPPED, SCPC_RUNNING} scpc_state_t;

  localparam int                STOP_W    = $clog2(STOP_CYCLES + 1);
  localparam logic [STOP_W-1:0] STOP_LAST = STOP_W'(STOP_CYCLES - 1);

  scpc_wr_t    req;
  scpc_en_t    en;
  scpc_state_t state_q, state_d;
  logic [STOP_W-1:0] stop_q, stop_d;
  logic        use_ext_q, use_ext_d, fixed_q, fixed_d;
  logic        halt_q, halt_d, cpu_sel_q, cpu_sel_d;
  logic [1:0]  pdiv_q, pdiv_d;
  logic [7:0]  rdata_d;
  logic [7:0]  cpu_m, pdiv_m, halt_m;
  logic        sys_tick;
  logic [1:0]  cpu_log2;

  assign req = '{wr: wr, bit_op: bit_op, bit_sel: bit_sel, addr: addr, wdata: wdata};

  function automatic logic [7:0] merge(input logic [7:0] cur, input scpc_wr_t r);
    logic [7:0] v;
    v = cur;
    if (r.bit_op)
      v[r.bit_sel] = r.wdata[0]; // Single-bit write
    else
      v = r.wdata; // Whole-byte write
    return v;
  endfunction

  always_comb
  begin
    state_d   = state_q;
    stop_d    = stop_q;
    use_ext_d = use_ext_q;
    fixed_d   = fixed_q;
    halt_d    = halt_q;
    cpu_sel_d = cpu_sel_q;
    pdiv_d    = pdiv_q;
    // Merged write values, built on current contents with unused bits at zero
    cpu_m     = merge({6'h00, cpu_sel_q, 1'b0}, req);
    pdiv_m    = merge({6'h00, pdiv_q}, req);
    halt_m    = merge({7'h00, halt_q}, req);
    case (state_q)
      SCPC_STOPPED:
      begin
        use_ext_d = opt_use_ext_clock; // Option sampled during stop
        fixed_d   = opt_slow_osc_fixed;
        if (stop_q >= STOP_LAST)
          state_d = SCPC_RUNNING; // Clock supplied only after stop time
        else
          stop_d = stop_q + 1'b1;
      end
      SCPC_RUNNING:
      begin
        if (req.wr && req.addr == SCPC_CPU_DIV_ADDR)
          cpu_sel_d = cpu_m[SCPC_CPU_SEL_BIT]; // Others ignored
        if (req.wr && req.addr == SCPC_PERIPH_DIV_ADDR)
          pdiv_d = pdiv_m[1:0];
        if (req.wr && req.addr == SCPC_SLOW_OSC_MODE_ADDR && !fixed_q)
          halt_d = halt_m[SCPC_HALT_BIT]; // Writes void when fixed
      end
      default: state_d = SCPC_STOPPED;
    endcase
    case (addr)
      SCPC_CPU_DIV_ADDR:       rdata_d = {6'h00, cpu_sel_q, 1'b0};
      SCPC_PERIPH_DIV_ADDR:    rdata_d = {6'h00, pdiv_q};
      SCPC_SLOW_OSC_MODE_ADDR: rdata_d = {7'h00, halt_q};
      default:                 rdata_d = 8'h00;
    endcase
  end

  // Fast source needs no stabilization wait; both run straight after stop time
  assign sys_tick = (state_q == SCPC_RUNNING) && (use_ext_q ? ext_clock_pin : fast_osc_tick);

  // CPU ratio = peripheral ratio times 4 when cpu_sel set, times 1 when clear: 1,2,4,4,8,16
  assign cpu_log2 = cpu_sel_q ? 2'd2 : 2'd0;

  scpc_div #(.WIDTH(2)) u_periph_div (
    .clock      (clock),
    .rst        (rst),
    .in_en      (sys_tick),
    .log2_ratio (pdiv_q == 2'b11 ? 2'd0 : pdiv_q), // 00 /1, 01 /2, 10 /4
    .out_en     (en.periph_en)
  );

  scpc_div #(.WIDTH(2)) u_cpu_div (
    .clock      (clock),
    .rst        (rst),
    .in_en      (en.periph_en), // CPU divides peripheral clock
    .log2_ratio (cpu_log2),
    .out_en     (en.cpu_en)
  );

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q             <= SCPC_STOPPED;
      stop_q              <= '0;
      use_ext_q           <= 1'b0;
      fixed_q             <= 1'b0;
      halt_q              <= SCPC_SLOW_OSC_MODE_RST[SCPC_HALT_BIT];
      cpu_sel_q           <= SCPC_CPU_DIV_RST[SCPC_CPU_SEL_BIT];
      pdiv_q              <= SCPC_PERIPH_DIV_RST[1:0];
      rdata               <= 8'h00;
      cpu_clk_en          <= 1'b0;
      periph_clk_en       <= 1'b0;
      slow_osc_run        <= 1'b1;
      watchdog_src_forced <= 1'b0;
      ext_pin_is_port     <= 1'b0;
      clock_ready         <= 1'b0;
    end
    else
    begin
      state_q             <= state_d;
      stop_q              <= stop_d;
      use_ext_q           <= use_ext_d;
      fixed_q             <= fixed_d;
      halt_q              <= halt_d;
      cpu_sel_q           <= cpu_sel_d;
      pdiv_q              <= pdiv_d;
      rdata               <= rdata_d;
      cpu_clk_en          <= en.cpu_en;
      periph_clk_en       <= en.periph_en;
      slow_osc_run        <= fixed_q || !halt_q;
      watchdog_src_forced <= fixed_q;
      ext_pin_is_port     <= (state_q == SCPC_RUNNING) && !use_ext_q;
      clock_ready         <= state_q == SCPC_RUNNING;
    end
  end

  // Checks on registers, stop time, dividers, slow oscillator, source start and pin release
  AST_RESET_DIV: assert property (@(posedge clock) rst |=> pdiv_q == 2'b10 && cpu_sel_q)
    else $error("Divider reset values wrong");
  AST_NO_CLK_STOP: assert property (@(posedge clock) disable iff (rst)
      state_q == SCPC_STOPPED |=> !periph_clk_en)
    else $error("Clock during stop time");
  AST_CPU_STOP: assert property (@(posedge clock) disable iff (rst)
      state_q == SCPC_STOPPED |=> !cpu_clk_en)
    else $error("CPU clock during stop time");
  AST_STOP_WR: assert property (@(posedge clock) disable iff (rst)
      state_q == SCPC_STOPPED |=> $stable(pdiv_q) && $stable(cpu_sel_q) && $stable(halt_q))
    else $error("Register written during stop time");
  AST_FIXED_RUN: assert property (@(posedge clock) disable iff (rst)
      fixed_q |=> slow_osc_run && watchdog_src_forced)
    else $error("Fixed slow oscillator stopped");
  AST_FIXED_WR: assert property (@(posedge clock) disable iff (rst)
      fixed_q |=> $stable(halt_q))
    else $error("Mode write taken while fixed");
  AST_HALT: assert property (@(posedge clock) disable iff (rst)
      !fixed_q && halt_q |=> !slow_osc_run)
    else $error("Halt bit ignored");
  AST_SLOW_RST: assert property (@(posedge clock) rst |=> halt_q == 1'b0)
    else $error("Mode register reset wrong");
  AST_SLOW_START: assert property (@(posedge clock) rst |=> slow_osc_run)
    else $error("Slow oscillator not running after reset");
  AST_PDIV_WR: assert property (@(posedge clock) disable iff (rst)
      state_q == SCPC_RUNNING && wr && !bit_op && addr == SCPC_PERIPH_DIV_ADDR |=> pdiv_q == $past(wdata[1:0]))
    else $error("Byte write to peripheral divider lost");
  AST_CPU_WR: assert property (@(posedge clock) disable iff (rst)
      state_q == SCPC_RUNNING && wr && bit_op && bit_sel == 3'd1 && addr == SCPC_CPU_DIV_ADDR |=> cpu_sel_q == $past(wdata[0]))
    else $error("Bit write to CPU divider lost");
  AST_CPU_SUB: assert property (@(posedge clock) disable iff (rst)
      en.cpu_en |-> en.periph_en)
    else $error("CPU tick without peripheral tick");
  AST_DIV1: assert property (@(posedge clock) disable iff (rst)
      en.periph_en && pdiv_q == 2'b00 ##1 !sys_tick ##1 sys_tick |-> en.periph_en)
    else $error("Undivided peripheral clock missing");
  AST_FAST_START: assert property (@(posedge clock) disable iff (rst)
      $rose(clock_ready) && !use_ext_q |-> ##[0:16] periph_clk_en)
    else $error("Fast source start delayed");
  AST_RDZERO: assert property (@(posedge clock) disable iff (rst)
      addr == SCPC_CPU_DIV_ADDR |=> rdata[7:2] == 6'h00 && rdata[0] == 1'b0)
    else $error("Unused bits not zero");
  AST_PORT: assert property (@(posedge clock) disable iff (rst)
      state_q == SCPC_RUNNING && !use_ext_q |=> ext_pin_is_port)
    else $error("External pin not released");
  AST_PIN_EXT: assert property (@(posedge clock) disable iff (rst)
      use_ext_q |=> !ext_pin_is_port)
    else $error("External clock pin released as port");
endmodule

/* File: sim/scpc_src_model.sv */
// Model of the fast oscillator and external clock sources
`timescale 1ns/10ps
module scpc_src_model #(
  parameter int FAST_PER = 2,
  parameter int EXT_PER  = 3
)(
  input  wire logic clock,
  output logic      fast_osc_tick,
  output logic      ext_clock_pin
);
  int fc = 0;
  int ec = 0;
  initial fast_osc_tick = 1'b0;
  initial ext_clock_pin = 1'b0;
  // One-cycle tick per source period
  always @(posedge clock)
  begin
    fc <= (fc + 1) % FAST_PER;
    ec <= (ec + 1) % EXT_PER;
    fast_osc_tick <= (fc == 0);
    ext_clock_pin <= (ec == 0);
  end
endmodule

/* File: sim/scpc_top_bench.sv */
// Self-checking bench for the clock prescaler control
`timescale 1ns/10ps
module scpc_top_bench;
  import scpc_pkg::*;
  localparam int STOP = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic opt_ext = 1'b0;
  logic opt_fix = 1'b0;
  logic fast_tick, ext_pin, cpu_en, per_en, slow_run, wd_forced, pin_port, ready;
  logic [7:0] rdata;
  scpc_wr_t req = '0;
  int failures = 0;
  int n_compared = 0;
  int n;
  logic [2:0] code [6] = '{3'b000, 3'b010, 3'b001, 3'b100, 3'b011, 3'b101};
  int cpu_r [6] = '{1, 2, 4, 4, 8, 16};
  int per_r [6] = '{1, 2, 1, 4, 2, 4};
  always #5 clock = ~clock;
  scpc_src_model src_u (.clock(clock), .fast_osc_tick(fast_tick), .ext_clock_pin(ext_pin));
  scpc_top #(.STOP_CYCLES(STOP)) dut_u (.clock(clock), .rst(rst), .opt_use_ext_clock(opt_ext),
    .opt_slow_osc_fixed(opt_fix), .fast_osc_tick(fast_tick), .ext_clock_pin(ext_pin), .wr(req.wr),
    .bit_op(req.bit_op), .bit_sel(req.bit_sel), .addr(req.addr), .wdata(req.wdata), .rdata(rdata),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .slow_osc_run(slow_run),
    .watchdog_src_forced(wd_forced), .ext_pin_is_port(pin_port), .clock_ready(ready));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h0, got}, {7'h0, exp}, what);
  endtask
  task automatic chk_int(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, input logic bop, input logic [2:0] b);
    @(posedge clock);
    req <= '{wr: 1'b1, bit_op: bop, bit_sel: b, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    req.addr <= a;
    repeat (2) @(posedge clock);
    #1 chk_byte(rdata, exp, what);
  endtask
  // Cycles between enable pulses, third interval taken to skip ratio changes
  task automatic period(input logic want_cpu, output int cnt);
    repeat (3)
    begin
      cnt = 0;
      do
      begin
        @(posedge clock);
        #1 cnt++;
      end while ((want_cpu ? cpu_en : per_en) !== 1'b1 && cnt < 200);
    end
  endtask
  task automatic boot(input logic ext, input logic fix);
    @(posedge clock);
    rst <= 1'b1;
    opt_ext <= ext;
    opt_fix <= fix;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk_bit(ready, 1'b0, "ready during stop");
    wr_reg(SCPC_CPU_DIV_ADDR, 8'h00, 1'b0, 3'h0);
    n = 0;
    while (ready !== 1'b1 && n < 2 * STOP)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk_bit(ready, 1'b1, "ready after stop");
    chk_int(n + 3, STOP + 1, "stop time cycles");
    rd_chk(SCPC_CPU_DIV_ADDR, SCPC_CPU_DIV_RST, "cpu div reset");
    rd_chk(SCPC_PERIPH_DIV_ADDR, SCPC_PERIPH_DIV_RST, "periph div reset");
    rd_chk(SCPC_SLOW_OSC_MODE_ADDR, SCPC_SLOW_OSC_MODE_RST, "mode reset");
    chk_bit(slow_run, 1'b1, "slow osc after reset");
    chk_bit(wd_forced, fix, "watchdog source forced");
    chk_bit(pin_port, ~ext, "pin as port");
  endtask
  task automatic close_out();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #300000;
    failures++;
    close_out();
  end
  initial
  begin
    boot(1'b0, 1'b0);
    $display("Test reset and fast boot done");
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(SCPC_PERIPH_DIV_ADDR, {6'h0, code[i][2:1]}, 1'b0, 3'h0);
      wr_reg(SCPC_CPU_DIV_ADDR, {7'h0, code[i][0]}, 1'b1, 3'h1);
      period(1'b1, n);
      chk_int(n, 2 * cpu_r[i], "cpu period");
      period(1'b0, n);
      chk_int(n, 2 * per_r[i], "periph period");
    end
    $display("Test divider codes done");
    wr_reg(SCPC_SLOW_OSC_MODE_ADDR, 8'hff, 1'b0, 3'h0);
    rd_chk(SCPC_SLOW_OSC_MODE_ADDR, 8'h01, "mode unused bits");
    chk_bit(slow_run, 1'b0, "slow osc stopped");
    wr_reg(SCPC_SLOW_OSC_MODE_ADDR, 8'h00, 1'b1, 3'h0);
    rd_chk(SCPC_SLOW_OSC_MODE_ADDR, 8'h00, "mode bit clear");
    chk_bit(slow_run, 1'b1, "slow osc restarted");
    wr_reg(SCPC_CPU_DIV_ADDR, 8'hfd, 1'b0, 3'h0);
    rd_chk(SCPC_CPU_DIV_ADDR, 8'h00, "cpu unused bits");
    wr_reg(SCPC_PERIPH_DIV_ADDR, 8'h01, 1'b1, 3'h7);
    rd_chk(SCPC_PERIPH_DIV_ADDR, 8'h02, "bit write unused");
    rd_chk(16'hff00, 8'h00, "unmapped read");
    $display("Test register access done");
    boot(1'b1, 1'b1);
    wr_reg(SCPC_SLOW_OSC_MODE_ADDR, 8'h01, 1'b0, 3'h0);
    rd_chk(SCPC_SLOW_OSC_MODE_ADDR, 8'h00, "fixed mode write");
    chk_bit(slow_run, 1'b1, "fixed osc runs");
    period(1'b0, n);
    chk_int(n, 12, "ext periph period");
    period(1'b1, n);
    chk_int(n, 48, "ext cpu period");
    $display("Test external fixed boot done");
    close_out();
  end
endmodule
